// ===== hpp_port.sv
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
// Summary of operation
// - The port and its strobes work only in the two single-chip modes; otherwise lines float.
// - Eight lines, each an input or output as its direction bit says.
// - Both strobes behave the same whatever the line directions are.
// - The control register has one status bit, the strobe-seen flag, plus three control bits.
// - A falling edge on input_strobe_n sets the strobe-seen flag.
// - With interrupt enable set, the interrupt line is asserted while the flag is set.
// - With latch enable set, the strobe edge captures the pins and holds them.
// - The flag clears only on a data access that follows a control read which saw it set.
// - A data register read makes the input latch transparent again, unless a latching strobe edge comes in the same cycle.
// - output_strobe_n pulses on data write if the select bit is 1, on data read if 0.
// - Output handshake: write, strobe out, peripheral acknowledge sets flag, software clears.
// - Clear direction bits make inputs, set bits make outputs.
module hpp_port #(
	parameter int unsigned PORT_W = hpp_pkg::PORT_W
) (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	input  wire logic [PORT_W-1:0]      port_in,
	output logic      [PORT_W-1:0]      port_out,
	output logic      [PORT_W-1:0]      port_oe,
	input  wire logic                   input_strobe_n,
	output logic                        output_strobe_n,
	output logic                        external_interrupt_line_n,
	output logic                        irq
);
	import hpp_pkg::*;

	generate
		if (PORT_W < 1 || PORT_W > 31) begin : g_bad_width
			$error("hpp_port width must lie between 1 and 31");
		end
	endgenerate

	logic [PORT_W:0]        sync_out;
	logic [PORT_W-1:0]      pins_s;
	logic                   strb_s;
	logic                   strb_prev_r;
	logic                   active;
	logic                   fall;

	logic                   acc;
	logic                   wr_pend_r;
	logic                   rd_pend_r;
	logic [ADDR_W-1:0]      wr_addr_r;
	logic [ADDR_W-1:0]      rd_addr_r;
	logic                   data_rd;
	logic                   data_wr;
	logic                   csr_rd;
	logic                   istat_rd;
	logic                   ostb_req;
	logic [31:0]            hrdata_nxt;

	logic [PORT_W-1:0]      dir_r;
	logic [MODE_W-1:0]      mode_r;
	logic                   le_r;
	logic                   strobe_on_write_select_r;
	logic                   ie_r;
	logic                   flag_r;
	hpp_clr_e               clr_r;
	logic [PORT_W-1:0]      latch_r;
	logic                   latched_r;
	logic [PORT_W-1:0]      in_val;
	logic [PORT_W-1:0]      data_val;
	logic [EV_W-1:0]        istat_r;
	logic [EV_W-1:0]        imask_r;
	logic [EV_W-1:0]        ev;
	logic [7:0]             csr_val;

	hpp_sync #(
		.W       (PORT_W + 1),
		.RST_VAL ({1'b1, {PORT_W{1'b0}}})
	) u_sync (
		.clk   (hclk),
		.rst_n (hresetn),
		.din   ({input_strobe_n, port_in}),
		.dout  (sync_out)
	);

	assign pins_s = sync_out[PORT_W-1:0];
	assign strb_s = sync_out[PORT_W];

	assign active = (mode_r == MODE_SC_A) || (mode_r == MODE_SC_B);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strb_prev_r <= 1'b1;
		end else begin
			strb_prev_r <= strb_s;
		end
	end

	assign fall = active && strb_prev_r && !strb_s;

	// bus address phase; reads take one wait so writes settle first
	assign acc = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			wr_addr_r <= '0;
			rd_addr_r <= '0;
		end else begin
			wr_pend_r <= acc && hwrite;
			rd_pend_r <= acc && !hwrite;
			if (acc && hwrite) begin
				wr_addr_r <= haddr[ADDR_W-1:0];
			end
			if (acc && !hwrite) begin
				rd_addr_r <= haddr[ADDR_W-1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (acc && !hwrite) begin
				hreadyout <= 1'b0;
			end else if (rd_pend_r) begin
				hreadyout <= 1'b1;
			end
		end
	end

	assign data_rd  = rd_pend_r && (rd_addr_r == OFS_DATA);
	assign data_wr  = wr_pend_r && (wr_addr_r == OFS_DATA);
	assign csr_rd   = rd_pend_r && (rd_addr_r == OFS_CSR);
	assign istat_rd = rd_pend_r && (rd_addr_r == OFS_ISTAT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_r <= '0;
		end else if (wr_pend_r && wr_addr_r == OFS_DIR) begin
			dir_r <= hwdata[PORT_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_out <= '0;
		end else if (data_wr) begin
			port_out <= hwdata[PORT_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_oe <= '0;
		end else begin
			port_oe <= active ? dir_r : '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			le_r                     <= CTRL_RST;
			strobe_on_write_select_r <= CTRL_RST;
			ie_r                     <= CTRL_RST;
		end else if (wr_pend_r && wr_addr_r == OFS_CSR) begin
			le_r                     <= hwdata[CSR_LE_BIT];
			strobe_on_write_select_r <= hwdata[CSR_STROBE_ON_WRITE_SELECT_BIT];
			ie_r                     <= hwdata[CSR_IE_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r <= MODE_RST;
		end else if (wr_pend_r && wr_addr_r == OFS_MODE) begin
			mode_r <= hwdata[MODE_W-1:0];
		end
	end

	// arm on control read with flag seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clr_r <= HPP_CLR_IDLE;
		end else begin
			case (clr_r)
				HPP_CLR_IDLE: begin
					if (csr_rd && flag_r) begin
						clr_r <= HPP_CLR_ARMED;
					end
				end
				HPP_CLR_ARMED: begin
					if (data_rd || data_wr) begin
						clr_r <= HPP_CLR_IDLE;
					end
				end
				default: begin
					clr_r <= HPP_CLR_IDLE;
				end
			endcase
		end
	end

	// edge sets flag; a new edge beats the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_r <= FLAG_RST;
		end else if (fall) begin
			flag_r <= 1'b1;
		end else if (clr_r == HPP_CLR_ARMED && (data_rd || data_wr)) begin
			flag_r <= 1'b0;
		end
	end

	// capture pins on the strobe edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_r   <= '0;
			latched_r <= 1'b0;
		end else if (fall && le_r) begin
			latch_r   <= pins_s;
			latched_r <= 1'b1;
		end else if (data_rd) begin
			latched_r <= 1'b0;
		end
	end

	assign in_val   = latched_r ? latch_r : pins_s;
	assign data_val = (dir_r & port_out) | (~dir_r & in_val);
	assign csr_val  = {flag_r, ie_r, 1'b0, strobe_on_write_select_r, le_r, 3'h0};

	assign ostb_req = active && (strobe_on_write_select_r ? data_wr : data_rd);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			output_strobe_n <= 1'b1;
		end else begin
			output_strobe_n <= !ostb_req;
		end
	end

	// level request while flag and enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			external_interrupt_line_n <= 1'b1;
		end else begin
			external_interrupt_line_n <= !(flag_r && ie_r);
		end
	end

	// sticky events, cleared by reading; a new event survives the read
	always_comb begin
		ev                = '0;
		ev[EV_STROBE_BIT] = fall;
		ev[EV_OSTB_BIT]   = ostb_req;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			istat_r <= ISTAT_RST;
		end else begin
			istat_r <= (istat_rd ? '0 : istat_r) | ev;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			imask_r <= IMASK_RST;
		end else if (wr_pend_r && wr_addr_r == OFS_IMASK) begin
			imask_r <= hwdata[EV_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(istat_r & imask_r);
		end
	end

	// flag is the only status bit of the control register
	always_comb begin
		hrdata_nxt = 32'h0000_0000;
		case (rd_addr_r)
			OFS_DATA:  hrdata_nxt = 32'(data_val);
			OFS_DIR:   hrdata_nxt = 32'(dir_r);
			OFS_CSR:   hrdata_nxt = 32'(csr_val);
			OFS_MODE:  hrdata_nxt = 32'(mode_r);
			OFS_ISTAT: hrdata_nxt = 32'(istat_r);
			OFS_IMASK: hrdata_nxt = 32'(imask_r);
			default:   hrdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pend_r) begin
			hrdata <= hrdata_nxt;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	ostb_cause_a: assert property (
		ostb_req |=> !output_strobe_n
	) else $error("output strobe missing after qualifying access");

	ostb_only_a: assert property (
		!output_strobe_n |-> $past(ostb_req)
	) else $error("output strobe without qualifying access");

	ostb_width_a: assert property (
		(!output_strobe_n && !ostb_req) |=> output_strobe_n
	) else $error("output strobe longer than one clock");

	flag_set_a: assert property (
		fall |=> flag_r
	) else $error("strobe edge did not set flag");

	flag_clear_a: assert property (
		$fell(flag_r) |-> $past(clr_r == HPP_CLR_ARMED && (data_rd || data_wr))
	) else $error("flag cleared without armed data access");

	latch_hold_a: assert property (
		(fall && le_r) |=> (latched_r && latch_r == $past(pins_s))
	) else $error("input latch did not capture pins");

	latch_open_a: assert property (
		(data_rd && !(fall && le_r)) |=> !latched_r
	) else $error("data read left latch closed");

	irq_line_a: assert property (
		(flag_r && ie_r) |=> !external_interrupt_line_n
	) else $error("interrupt line not asserted");

	irq_quiet_a: assert property (
		!(flag_r && ie_r) |=> external_interrupt_line_n
	) else $error("interrupt line asserted without cause");

	dir_oe_a: assert property (
		1'b1 |=> port_oe == ($past(active) ? $past(dir_r) : '0)
	) else $error("output enables disagree with direction and mode");

endmodule : hpp_port

// ===== hpp_pkg.sv
package hpp_pkg;

	localparam int unsigned PORT_W        = 8;
	localparam int unsigned ADDR_W        = 8;

	localparam logic [7:0]  OFS_DATA      = 8'h00;
	localparam logic [7:0]  OFS_DIR       = 8'h04;
	localparam logic [7:0]  OFS_CSR       = 8'h08;
	localparam logic [7:0]  OFS_MODE      = 8'h0c;
	localparam logic [7:0]  OFS_ISTAT     = 8'h10;
	localparam logic [7:0]  OFS_IMASK     = 8'h14;

	localparam int unsigned CSR_FLAG_BIT  = 7;
	localparam int unsigned CSR_IE_BIT    = 6;
	localparam int unsigned CSR_STROBE_ON_WRITE_SELECT_BIT = 4;
	localparam int unsigned CSR_LE_BIT    = 3;

	localparam int unsigned MODE_W        = 3;
	localparam logic [2:0]  MODE_SC_A     = 3'h7;
	localparam logic [2:0]  MODE_SC_B     = 3'h4;
	localparam logic [2:0]  MODE_RST      = 3'h7;

	localparam int unsigned EV_W          = 2;
	localparam int unsigned EV_STROBE_BIT = 0;
	localparam int unsigned EV_OSTB_BIT   = 1;
	localparam logic [1:0]  IMASK_RST     = 2'h0;
	localparam logic [1:0]  ISTAT_RST     = 2'h0;

	localparam logic        CTRL_RST      = 1'b0;
	localparam logic        FLAG_RST      = 1'b0;

	localparam int unsigned SYNC_STAGES   = 3;

	typedef enum logic [0:0] {
		HPP_CLR_IDLE  = 1'b0,
		HPP_CLR_ARMED = 1'b1
	} hpp_clr_e;

endpackage : hpp_pkg

// ===== hpp_sync.sv
`timescale 1ns/10ps
module hpp_sync #(
	parameter int unsigned W       = 9,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	import hpp_pkg::*;

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	generate
		if (W < 1) begin : g_bad_w
			$error("hpp_sync width must be at least one");
		end
	endgenerate

	// stage one feeds stage two only; metastability stays contained
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a bit changes only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= RST_VAL;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					dout[i] <= s3_r[i];
				end
			end
		end
	end

endmodule : hpp_sync

// ===== hpp_periph.sv
`timescale 1ns/10ps
module hpp_periph (
	input  wire logic       hclk,
	input  wire logic       key_go,
	input  wire logic       ack_en,
	input  wire logic [3:0] ack_dly,
	input  wire logic [7:0] pin_val,
	input  wire logic [7:0] port_out,
	input  wire logic [7:0] port_oe,
	input  wire logic       output_strobe_n,
	output logic      [7:0] port_in,
	output logic            input_strobe_n
);
	int dly_r = 0;
	int low_r = 0;
	assign port_in = (port_oe & port_out) | (~port_oe & pin_val);
	always @(posedge hclk) begin
		if (ack_en && !output_strobe_n)
			dly_r <= ack_dly;
		else if (dly_r > 0)
			dly_r <= dly_r - 1;
		// wide pulse so the synchroniser never filters it
		if (key_go || dly_r == 1)
			low_r <= 4;
		else if (low_r > 0)
			low_r <= low_r - 1;
	end
	assign input_strobe_n = (low_r == 0);
endmodule : hpp_periph

// ===== tb.sv
`timescale 1ns/10ps
module tb;
	import hpp_pkg::*;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [2:0]  hsize   = 3'h2;
	logic [31:0] hwdata  = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  port_in;
	logic [7:0]  port_out;
	logic [7:0]  port_oe;
	logic [7:0]  pin_val = 8'h80;
	logic        input_strobe_n;
	logic        output_strobe_n;
	logic        ext_n;
	logic        irq;
	logic        key_go  = 1'b0;
	logic        ack_en  = 1'b0;
	logic [3:0]  ack_dly = 4'h9;
	logic [31:0] q;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          n_low = 0;

	always #2.5 hclk = ~hclk;
	always @(posedge hclk) if (!output_strobe_n) n_low <= n_low + 1;

	hpp_port u_hpp_port (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .port_in, .port_out, .port_oe,
		.input_strobe_n, .output_strobe_n, .external_interrupt_line_n(ext_n), .irq);
	hpp_periph u_hpp_periph (.hclk, .key_go, .ack_en, .ack_dly, .pin_val, .port_out,
		.port_oe, .output_strobe_n, .port_in, .input_strobe_n);

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// address phase held until ready, then data phase until ready
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus

	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	task key;
		key_go <= 1'b1;
		@(posedge hclk);
		key_go <= 1'b0;
		cyc(14);
	endtask : key

	task t_reset;
		bus(0, OFS_DIR, 0);
		check("dir", q, 0);
		bus(0, OFS_CSR, 0);
		check("csr", q, 0);
		check("idle pins", {port_oe, output_strobe_n, ext_n, irq, hresp}, 12'hc);
	endtask : t_reset

	task t_dir;
		bus(1, OFS_DIR, 32'h7f);
		bus(1, OFS_DATA, 32'h55);
		cyc(2);
		check("oe", port_oe, 8'h7f);
		check("out", port_out, 8'h55);
		bus(0, OFS_DATA, 0);
		check("mixed read", q, 32'hd5);
	endtask : t_dir

	task t_ostb_write;
		logic [31:0] sel;
		sel = 32'h1 << CSR_STROBE_ON_WRITE_SELECT_BIT;
		bus(1, OFS_CSR, sel);
		ack_en <= 1'b1;
		n_low = 0;
		bus(1, OFS_DATA, 32'h41);
		cyc(24);
		check("write pulse", n_low, 1);
		bus(0, OFS_CSR, 0);
		check("ack flag", q, (32'h1 << CSR_FLAG_BIT) | sel);
		ack_en <= 1'b0;
		bus(1, OFS_DATA, 32'h42);
		bus(0, OFS_CSR, 0);
		check("cleared", q, sel);
	endtask : t_ostb_write

	task t_ostb_read;
		bus(1, OFS_DIR, 0);
		bus(1, OFS_CSR, 0);
		n_low = 0;
		bus(1, OFS_DATA, 32'h1);
		cyc(3);
		check("no write pulse", n_low, 0);
		bus(0, OFS_DATA, 0);
		cyc(3);
		check("read pulse", n_low, 1);
	endtask : t_ostb_read

	task t_clear_order;
		key;
		bus(0, OFS_DATA, 0);
		bus(0, OFS_CSR, 0);
		check("flag kept", q[CSR_FLAG_BIT], 1'b1);
		bus(0, OFS_DATA, 0);
		bus(0, OFS_CSR, 0);
		check("flag gone", q[CSR_FLAG_BIT], 1'b0);
	endtask : t_clear_order

	task t_latch;
		bus(1, OFS_CSR, 32'h1 << CSR_LE_BIT);
		pin_val <= 8'h3c;
		cyc(6);
		key;
		pin_val <= 8'ha5;
		cyc(6);
		bus(0, OFS_DATA, 0);
		check("held", q, 32'h3c);
		bus(0, OFS_DATA, 0);
		check("transparent", q, 32'ha5);
		bus(0, OFS_CSR, 0);
		bus(0, OFS_DATA, 0);
	endtask : t_latch

	task t_irq;
		bus(0, OFS_ISTAT, 0);
		check("istat events", q, (32'h1 << EV_STROBE_BIT) | (32'h1 << EV_OSTB_BIT));
		bus(1, OFS_IMASK, 0);
		bus(1, OFS_CSR, 32'h1 << CSR_IE_BIT);
		key;
		check("int line", ext_n, 1'b0);
		check("irq masked", irq, 1'b0);
		bus(1, OFS_IMASK, 32'h1 << EV_STROBE_BIT);
		cyc(2);
		check("irq", irq, 1'b1);
		bus(0, OFS_ISTAT, 0);
		check("istat", q, 32'h1 << EV_STROBE_BIT);
		cyc(2);
		check("irq clear", irq, 1'b0);
		bus(0, OFS_CSR, 0);
		bus(1, OFS_DATA, 0);
		cyc(2);
		check("int line off", ext_n, 1'b1);
	endtask : t_irq

	task t_mode;
		bus(1, OFS_DIR, 32'hff);
		bus(1, OFS_MODE, 32'h2);
		bus(1, OFS_CSR, 32'h1 << CSR_STROBE_ON_WRITE_SELECT_BIT);
		cyc(2);
		check("oe off", port_oe, 8'h0);
		n_low = 0;
		bus(1, OFS_DATA, 32'h3);
		key;
		check("no pulse", n_low, 0);
		bus(0, OFS_CSR, 0);
		check("no flag", q, 32'h1 << CSR_STROBE_ON_WRITE_SELECT_BIT);
		bus(1, OFS_MODE, {29'h0, MODE_SC_B});
		cyc(2);
		check("oe on", port_oe, 8'hff);
		n_low = 0;
		bus(1, OFS_DATA, 32'h4);
		cyc(2);
		check("pulse", n_low, 1);
		bus(1, 8'h18, 32'hffff);
		bus(0, 8'h18, 0);
		check("unmapped", q, 0);
		bus(1, OFS_CSR, 32'hff);
		bus(0, OFS_CSR, 0);
		check("csr bits", q, 32'h58);
	endtask : t_mode

	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	initial begin
		cyc(20);
		hresetn <= 1'b1;
		t_reset;
		t_dir;
		t_ostb_write;
		t_ostb_read;
		t_clear_order;
		t_latch;
		t_irq;
		t_mode;
		complete_run;
	end

	// the whole sequence takes well under a thousand cycles
	initial begin
		cyc(20000);
		n_mismatch++;
		complete_run;
	end
endmodule : tb
